//--- rtl/scp_pkg.sv
// Constants and state types shared by the serial configuration port.
package scp_pkg;

  // Command opcodes carried in the first byte of a frame.
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ  = 8'h03;

  // Register addresses carried in the second byte of a frame.
  localparam logic [7:0] ADDR_REVISION = 8'h00;
  localparam logic [7:0] ADDR_AMP1     = 8'h01;
  localparam logic [7:0] ADDR_AMP2     = 8'h02;
  localparam logic [7:0] ADDR_MOD      = 8'h03;
  localparam logic [7:0] ADDR_BIAS     = 8'h04;

  localparam int REG_W = 8;

  // Bit positions inside a frame, counted from the first bit after chip select falls.
  localparam logic [4:0] BIT_FIRST       = 5'h00;
  localparam logic [4:0] BIT_HEADER_LAST = 5'h0F;
  localparam logic [4:0] BIT_DATA_FIRST  = 5'h10;
  localparam logic [4:0] BIT_FRAME_LAST  = 5'h17;

  // Amplifier register fields.
  localparam int AMP_POWER_DOWN_CONTROL_BIT   = 7;
  localparam int AMP_SEL_HI_BIT = 5;
  localparam int AMP_SEL_LO_BIT = 4;
  localparam int AMP_SHIELD_BIT = 3;
  localparam int AMP_GAIN_HI    = 2;
  localparam int AMP_GAIN_LO    = 0;

  // Modulator register fields.
  localparam int MOD_IDLE_TONE_OFFSET_DISABLE_DIS_BIT = 7;
  localparam int MOD_HP_BIT       = 6;
  localparam int MOD_PWDN1_BIT    = 5;
  localparam int MOD_PWDN2_BIT    = 4;

  // Reset values.
  localparam logic [7:0] AMP1_RESET = 8'h00;
  localparam logic [7:0] AMP2_RESET = 8'h00;
  localparam logic [7:0] MOD_RESET  = 8'h00;
  localparam logic [7:0] BIAS_RESET = 8'h00;

  // Fastest serial clock the master may apply, and its period in system clocks.
  localparam int SCLK_MAX_KHZ         = 4096;
  localparam int CLK_PERIOD_NS        = 40;
  localparam int SCLK_MIN_PERIOD_CLKS =
    (1000000 + SCLK_MAX_KHZ * CLK_PERIOD_NS - 1) / (SCLK_MAX_KHZ * CLK_PERIOD_NS);

  // State clocked on the rising serial clock edge.
  typedef struct packed {
    logic        rst_meta;
    logic        rst_sync;
    logic [4:0]  cnt;
    logic [23:0] shift;
    logic        rd_active;
    logic [7:0]  out_byte;
    logic        rq_tgl;
    logic        wr_tgl;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
  } scp_link_st_type;

  // State clocked on the falling serial clock edge.
  typedef struct packed {
    logic sdo;
    logic oe;
  } scp_out_st_type;

  // State clocked by the system clock.
  typedef struct packed {
    logic        wr_s1;
    logic        wr_s2;
    logic        wr_s3;
    logic        rq_s1;
    logic        rq_s2;
    logic        rq_s3;
    logic [7:0]  amp1;
    logic [7:0]  amp2;
    logic [7:0]  modc;
    logic [7:0]  bias;
    logic [31:0] snap;
  } scp_sys_st_type;

endpackage

//--- rtl/scp_spi_config_port.sv
// Serial configuration port: mode 0 slave with four 8-bit configuration registers and a read-only revision byte.
`timescale 1ns/100ps

module scp_spi_config_port #(
  // Revision code; the value is arbitrary.
  parameter logic [7:0] REVISION_CODE = 8'hA5
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       sclk,
  input  wire logic                       cs_n,
  input  wire logic                       sdi,
  output logic                            sdo,
  output logic                            sdo_oe,
  output logic                            amp1_power_down_control,
  output logic [1:0]                      amp1_input_select,
  output logic [2:0]                      amp1_amplification_code,
  output logic                            shield_drive_enable,
  output logic                            amp2_power_down_control,
  output logic [1:0]                      amp2_input_select,
  output logic [2:0]                      amp2_amplification_code,
  output logic                            idle_tone_offset_disable,
  output logic                            high_performance_mode,
  output logic                            mod1_power_down_control,
  output logic                            mod2_power_down_control,
  output logic [scp_pkg::REG_W-1:0]       bias_power_config
);
  import scp_pkg::*;

  // Byte returned for a read of the given address from the snapshot image.
  function automatic logic [7:0] read_byte(input logic [7:0]  addr,
                                           input logic [31:0] img);
    logic [7:0] res;
    res = 8'h00;
    case (addr)
      ADDR_REVISION: res = REVISION_CODE;
      ADDR_AMP1:     res = img[7:0];
      ADDR_AMP2:     res = img[15:8];
      ADDR_MOD:      res = img[23:16];
      ADDR_BIAS:     res = img[31:24];
      default:       res = 8'h00;
    endcase
    return res;
  endfunction

  // True for an address that software may write.
  function automatic logic writable(input logic [7:0] addr);
    return (addr >= ADDR_AMP1) && (addr <= ADDR_BIAS);
  endfunction

  scp_link_st_type link_r;
  scp_link_st_type link_nxt;
  scp_out_st_type  out_r;
  scp_out_st_type  out_nxt;
  scp_sys_st_type  sys_r;
  scp_sys_st_type  sys_nxt;

  logic [23:0] shift_in;
  logic [2:0]  bit_idx;
  logic        wr_evt;
  logic        rq_evt;

  assign shift_in = {link_r.shift[22:0], sdi};
  assign bit_idx  = 3'(BIT_FRAME_LAST - link_r.cnt);
  assign wr_evt   = sys_r.wr_s2 ^ sys_r.wr_s3;
  assign rq_evt   = sys_r.rq_s2 ^ sys_r.rq_s3;

  // ---------------------------------------------------------------------------
  // Link logic on the rising serial clock edge.
  // The reset reaches this domain through two flops, so the serial clock must
  // run for a few cycles while reset is held for the link state to clear.
  // ---------------------------------------------------------------------------
  always_comb begin
    link_nxt          = link_r;
    link_nxt.rst_meta = rst;
    link_nxt.rst_sync = link_r.rst_meta;
    if (link_r.rst_sync) begin
      link_nxt.cnt       = BIT_FIRST;
      link_nxt.shift     = 24'h00_0000;
      link_nxt.rd_active = 1'b0;
      link_nxt.out_byte  = 8'h00;
      link_nxt.rq_tgl    = 1'b0;
      link_nxt.wr_tgl    = 1'b0;
      link_nxt.wr_addr   = 8'h00;
      link_nxt.wr_data   = 8'h00;
    end else if (cs_n) begin
      // Clocks with select high only flush the partial frame.
      link_nxt.cnt       = BIT_FIRST;
      link_nxt.rd_active = 1'b0;
    end else begin
      link_nxt.shift = shift_in;
      if (link_r.cnt == BIT_FRAME_LAST) begin
        link_nxt.cnt = BIT_FIRST;
      end else begin
        link_nxt.cnt = 5'(link_r.cnt + 5'h01);
      end
      if (link_r.cnt == BIT_FIRST) begin
        // Ask the system side for a fresh register image well before it is needed.
        link_nxt.rq_tgl = ~link_r.rq_tgl;
      end
      if (link_r.cnt == BIT_HEADER_LAST && shift_in[15:8] == OP_READ) begin
        link_nxt.rd_active = 1'b1;
        link_nxt.out_byte  = read_byte(shift_in[7:0], sys_r.snap);
      end
      if (link_r.cnt == BIT_FRAME_LAST) begin
        link_nxt.rd_active = 1'b0;
        if (shift_in[23:16] == OP_WRITE && writable(shift_in[15:8])) begin
          link_nxt.wr_addr = shift_in[15:8];
          link_nxt.wr_data = shift_in[7:0];
          link_nxt.wr_tgl  = ~link_r.wr_tgl;
        end
      end
    end
  end

  always_ff @(posedge sclk) begin
    link_r <= link_nxt;
  end

  // ---------------------------------------------------------------------------
  // Serial output on the falling edge, driven only in the data byte of a read.
  // ---------------------------------------------------------------------------
  always_comb begin
    out_nxt    = out_r;
    out_nxt.oe = !link_r.rst_sync && !cs_n && link_r.rd_active
                 && (link_r.cnt >= BIT_DATA_FIRST);
    if (out_nxt.oe) begin
      out_nxt.sdo = link_r.out_byte[bit_idx];
    end else begin
      out_nxt.sdo = 1'b0;
    end
  end

  always_ff @(negedge sclk) begin
    out_r <= out_nxt;
  end

  assign sdo    = out_r.sdo;
  assign sdo_oe = out_r.oe;

  // ---------------------------------------------------------------------------
  // System side: configuration registers and the read image.
  // Write address and data are held by the link for a whole frame after the
  // toggle, so they are still stable when the synchronised toggle is seen.
  // ---------------------------------------------------------------------------
  always_comb begin
    sys_nxt       = sys_r;
    sys_nxt.wr_s1 = link_r.wr_tgl;
    sys_nxt.wr_s2 = sys_r.wr_s1;
    sys_nxt.wr_s3 = sys_r.wr_s2;
    sys_nxt.rq_s1 = link_r.rq_tgl;
    sys_nxt.rq_s2 = sys_r.rq_s1;
    sys_nxt.rq_s3 = sys_r.rq_s2;
    if (rst) begin
      sys_nxt.amp1 = AMP1_RESET;
      sys_nxt.amp2 = AMP2_RESET;
      sys_nxt.modc = MOD_RESET;
      sys_nxt.bias = BIAS_RESET;
      sys_nxt.snap = {BIAS_RESET, MOD_RESET, AMP2_RESET, AMP1_RESET};
    end else begin
      if (wr_evt) begin
        case (link_r.wr_addr)
          ADDR_AMP1: sys_nxt.amp1 = link_r.wr_data;
          ADDR_AMP2: sys_nxt.amp2 = link_r.wr_data;
          ADDR_MOD:  sys_nxt.modc = link_r.wr_data;
          ADDR_BIAS: sys_nxt.bias = link_r.wr_data;
          default:   sys_nxt.amp1 = sys_r.amp1;
        endcase
      end
      if (rq_evt) begin
        // Taking the next values lets a write that lands now show in the image.
        sys_nxt.snap = {sys_nxt.bias, sys_nxt.modc, sys_nxt.amp2, sys_nxt.amp1};
      end
    end
  end

  always_ff @(posedge clk) begin
    sys_r <= sys_nxt;
  end

  // Gain code 111 is stored and passed on unchanged; the amplifier treats it as reserved.
  assign amp1_power_down_control  = sys_r.amp1[AMP_POWER_DOWN_CONTROL_BIT];
  assign amp1_input_select        = sys_r.amp1[AMP_SEL_HI_BIT:AMP_SEL_LO_BIT];
  assign amp1_amplification_code  = sys_r.amp1[AMP_GAIN_HI:AMP_GAIN_LO];
  assign shield_drive_enable      = sys_r.amp1[AMP_SHIELD_BIT];
  assign amp2_power_down_control  = sys_r.amp2[AMP_POWER_DOWN_CONTROL_BIT];
  assign amp2_input_select        = sys_r.amp2[AMP_SEL_HI_BIT:AMP_SEL_LO_BIT];
  assign amp2_amplification_code  = sys_r.amp2[AMP_GAIN_HI:AMP_GAIN_LO];
  assign idle_tone_offset_disable = sys_r.modc[MOD_IDLE_TONE_OFFSET_DISABLE_DIS_BIT];
  assign high_performance_mode    = sys_r.modc[MOD_HP_BIT];
  assign mod1_power_down_control  = sys_r.modc[MOD_PWDN1_BIT];
  assign mod2_power_down_control  = sys_r.modc[MOD_PWDN2_BIT];
  assign bias_power_config        = sys_r.bias;

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  logic out_bit_now;
  assign out_bit_now = link_r.out_byte[bit_idx];

  reset_defaults_a: assert property (
    @(posedge clk) rst |=> (sys_r.amp1 == AMP1_RESET && sys_r.modc == MOD_RESET
                            && bias_power_config == BIAS_RESET && sys_r.amp2 == AMP2_RESET))
    else $error("Registers not at defaults after reset.");

  // The link state is unknown until the synchronised reset has reached it, so
  // the antecedent waits for a known, released reset.
  deselect_flush_a: assert property (
    @(posedge sclk) disable iff (link_r.rst_sync)
    (!link_r.rst_sync && cs_n)
    |=> (link_r.cnt == BIT_FIRST && !link_r.rd_active && $stable(link_r.wr_tgl)))
    else $error("Deselected clocks changed link state.");

  frame_wrap_a: assert property (
    @(posedge sclk) disable iff (link_r.rst_sync)
    (!cs_n && link_r.cnt == BIT_FRAME_LAST) |=> (link_r.cnt == BIT_FIRST))
    else $error("Frame did not end after 24 bits.");

  write_target_a: assert property (
    @(posedge sclk) disable iff (link_r.rst_sync)
    $changed(link_r.wr_tgl) |-> (writable(link_r.wr_addr) && link_r.wr_addr != ADDR_REVISION))
    else $error("Write issued to a protected or unmapped address.");

  read_load_a: assert property (
    @(posedge sclk) disable iff (link_r.rst_sync)
    (!cs_n && link_r.cnt == BIT_HEADER_LAST && link_r.shift[14:7] == OP_READ)
    |=> (link_r.rd_active && link_r.out_byte == read_byte(link_r.shift[7:0], sys_r.snap)))
    else $error("Read byte not loaded after address byte.");

  sdo_drive_a: assert property (
    @(negedge sclk) disable iff (link_r.rst_sync)
    (!cs_n && link_r.rd_active && link_r.cnt >= BIT_DATA_FIRST)
    |=> (sdo_oe && sdo == $past(out_bit_now)))
    else $error("Read data bit not driven on falling edge.");

  sdo_release_a: assert property (
    @(negedge sclk) (!link_r.rst_sync && cs_n) |=> !sdo_oe)
    else $error("Serial output driven while deselected.");

  sdo_quiet_a: assert property (
    @(negedge sclk) !sdo_oe |-> (sdo == 1'b0))
    else $error("Serial output not low while released.");

  count_range_a: assert property (
    @(posedge sclk) disable iff (link_r.rst_sync)
    !link_r.rst_sync |-> (link_r.cnt <= BIT_FRAME_LAST))
    else $error("Bit counter left the frame.");

  write_apply_a: assert property (
    @(posedge clk) disable iff (rst)
    (wr_evt && link_r.wr_addr == ADDR_AMP1) |=> (sys_r.amp1 == $past(link_r.wr_data)))
    else $error("Write to amplifier 1 register not applied.");

  image_update_a: assert property (
    @(posedge clk) disable iff (rst)
    (rq_evt && !wr_evt) ##1 1'b1 |-> (sys_r.snap == {sys_r.bias, sys_r.modc, sys_r.amp2, sys_r.amp1}))
    else $error("Read image not refreshed from registers.");

  amp2_apply_a: assert property (
    @(posedge clk) disable iff (rst)
    (wr_evt && link_r.wr_addr == ADDR_AMP2) |=> (sys_r.amp2 == $past(link_r.wr_data)))
    else $error("Write to amplifier 2 register not applied.");

  mod_apply_a: assert property (
    @(posedge clk) disable iff (rst)
    (wr_evt && link_r.wr_addr == ADDR_MOD) |=> (sys_r.modc == $past(link_r.wr_data)))
    else $error("Write to modulator register not applied.");

  bias_apply_a: assert property (
    @(posedge clk) disable iff (rst)
    (wr_evt && link_r.wr_addr == ADDR_BIAS) |=> (sys_r.bias == $past(link_r.wr_data)))
    else $error("Write to bias register not applied.");

  // Without a write event every register must hold, which also covers refused frames.
  regs_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !wr_evt |=> ($stable(sys_r.amp1) && $stable(sys_r.amp2)
                 && $stable(sys_r.modc) && $stable(sys_r.bias)))
    else $error("Register changed without a write.");

endmodule

//--- dv/scp_spi_master.sv
// Serial master model that frames transfers into the configuration port.
`timescale 1ns/100ps
module scp_spi_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  // A 160 ns period runs the serial clock faster than the port's 4096 kHz limit.
  localparam int HALF_NS = 80;
  logic stale;
  logic line;
  // A released output line shows a changing pattern, never the last bit driven.
  assign line = sdo_oe ? sdo : stale;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    stale = 1'b0;
  end
  // Sends nbits of tx MSB first; sel low gives clocks with select high.
  task automatic frame(input logic [23:0] tx, input int nbits, input logic sel,
                       input logic hold, output logic [23:0] rx, output logic [23:0] oe);
    rx = '0;
    oe = '0;
    #7;
    cs_n = ~sel;
    for (int i = 23; i > 23 - nbits; i--) begin
      sdi = tx[i];
      #HALF_NS sclk = 1'b1;
      rx[i] = line;
      oe[i] = sdo_oe;
      stale = ~stale;
      #HALF_NS sclk = 1'b0;
    end
    sdi = ~sdi;
    #20;
    if (!hold) begin
      cs_n = 1'b1;
    end
  endtask
endmodule

//--- dv/scp_spi_config_port_tb.sv
// Self-checking bench for the serial configuration port.
`timescale 1ns/100ps
module scp_spi_config_port_tb;
  import scp_pkg::*;
  // The revision value is arbitrary.
  localparam logic [7:0] REV = 8'h5C;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sclk, cs_n, sdi, sdo, sdo_oe;
  logic        a1_pd, a1_sh, a2_pd, ofs_dis, hp, m1_pd, m2_pd;
  logic [1:0]  a1_sel, a2_sel;
  logic [2:0]  a1_gn, a2_gn;
  logic [7:0]  bias;
  logic [7:0]  exp_r [0:4];
  logic [23:0] rx, oe;
  int          n_errors = 0;
  int          n_checks = 0;
  always #20 clk = ~clk;
  scp_spi_config_port #(.REVISION_CODE(REV)) u_scp_spi_config_port (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .amp1_power_down_control(a1_pd), .amp1_input_select(a1_sel),
    .amp1_amplification_code(a1_gn), .shield_drive_enable(a1_sh),
    .amp2_power_down_control(a2_pd), .amp2_input_select(a2_sel),
    .amp2_amplification_code(a2_gn), .idle_tone_offset_disable(ofs_dis),
    .high_performance_mode(hp), .mod1_power_down_control(m1_pd),
    .mod2_power_down_control(m2_pd), .bias_power_config(bias));
  scp_spi_master u_scp_spi_master (
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // The wait after each frame covers the crossing of a write into the system domain.
  task automatic xfer(input logic [7:0] op, input logic [7:0] ad, input logic [7:0] dt,
                      input int nbits = 24, input logic sel = 1'b1, input logic hold = 1'b0);
    u_scp_spi_master.frame({op, ad, dt}, nbits, sel, hold, rx, oe);
    repeat (4) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    xfer(OP_WRITE, ad, dt);
    if (ad >= ADDR_AMP1 && ad <= ADDR_BIAS) begin
      exp_r[ad[2:0]] = dt;
    end
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    xfer(OP_READ, ad, 8'h00);
    check({16'h0000, rx[7:0]}, {16'h0000, e});
    check(oe, 24'h00_00FF);
    check({23'h00_0000, sdo_oe}, 24'h00_0000);
  endtask
  task automatic check_regs();
    check({16'h0000, a1_pd, 1'b0, a1_sel, a1_sh, a1_gn}, {16'h0000, exp_r[1] & 8'hBF});
    check({16'h0000, a2_pd, 1'b0, a2_sel, 1'b0, a2_gn}, {16'h0000, exp_r[2] & 8'hB7});
    check({16'h0000, ofs_dis, hp, m1_pd, m2_pd, 4'h0}, {16'h0000, exp_r[3] & 8'hF0});
    check({16'h0000, bias}, {16'h0000, exp_r[4]});
  endtask
  initial begin
    exp_r = '{REV, 8'h00, 8'h00, 8'h00, 8'h00};
    rx = '0;
    oe = '0;
    repeat (4) @(negedge clk);
    xfer(8'h00, 8'h00, 8'h00, 24, 1'b0);
    check_regs();
    rst = 1'b0;
    xfer(8'h00, 8'h00, 8'h00, 8, 1'b0);
    for (int a = 0; a <= 4; a++) rd(a[7:0], exp_r[a]);
    wr(ADDR_AMP1, 8'h20);
    wr(ADDR_AMP2, 8'h20);
    wr(ADDR_MOD, 8'h40);
    wr(ADDR_BIAS, 8'h8F);
    check_regs();
    for (int a = 0; a <= 4; a++) rd(a[7:0], exp_r[a]);
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_AMP2, {k[0], 1'b0, k[1:0], 1'b0, k[2:0]});
      check_regs();
    end
    wr(ADDR_AMP1, 8'hBD);
    rd(ADDR_AMP1, 8'hBD);
    wr(ADDR_MOD, 8'h30);
    check_regs();
    wr(ADDR_MOD, 8'hC0);
    wr(ADDR_BIAS, 8'h00);
    check_regs();
    wr(ADDR_REVISION, 8'hFF);
    wr(8'h05, 8'hFF);
    xfer(8'h01, ADDR_AMP1, 8'h00);
    check_regs();
    rd(ADDR_REVISION, REV);
    rd(8'h05, 8'h00);
    rd(8'hFF, 8'h00);
    xfer(OP_WRITE, ADDR_BIAS, 8'h55, 20);
    xfer(OP_WRITE, ADDR_BIAS, 8'h55, 24, 1'b0);
    check_regs();
    wr(ADDR_BIAS, 8'h8F);
    check_regs();
    xfer(OP_WRITE, ADDR_AMP1, 8'h2A, 24, 1'b1, 1'b1);
    exp_r[1] = 8'h2A;
    rd(ADDR_BIAS, 8'h8F);
    check_regs();
    @(negedge clk);
    rst = 1'b1;
    xfer(8'h00, 8'h00, 8'h00, 24, 1'b0);
    exp_r = '{REV, 8'h00, 8'h00, 8'h00, 8'h00};
    check_regs();
    rst = 1'b0;
    xfer(8'h00, 8'h00, 8'h00, 8, 1'b0);
    rd(ADDR_MOD, 8'h00);
    wr(ADDR_MOD, 8'h40);
    rd(ADDR_MOD, 8'h40);
    end_of_test();
  end
  // A hang anywhere in the sequence is cut short and counted.
  initial begin
    #1_000_000;
    n_errors++;
    end_of_test();
  end
endmodule
